//--- pkg/gearbox_pkg.sv
// shared types and constants of the output serializer gearbox
package gearbox_pkg;

  // ==========================================================
  // modes and word layout
  typedef enum logic [1:0] {
    MODE_SEVEN_TO_ONE = 2'b00,
    MODE_EIGHT_TO_ONE = 2'b01,
    MODE_FOUR_TO_ONE = 2'b10
  } gear_mode_t;

  localparam int WORD_W = 8;
  localparam int LANE_B_BIT = 4;
  localparam logic [3:0] LEN_SEVEN = 4'h7;
  localparam logic [3:0] LEN_EIGHT = 4'h8;
  localparam logic [3:0] LEN_FOUR = 4'h4;

  // ==========================================================
  // slot positions of the three pipeline stages
  localparam logic [3:0] SLOT_CAPTURE = 4'h0;
  localparam logic [3:0] SLOT_TRANSFER = 4'h1;
  localparam logic [3:0] SLOT_LOAD = 4'h2;

  // ==========================================================
  // reset values
  localparam logic [7:0] WORD_RST = 8'h00;
  localparam logic [3:0] SLOT_RST = 4'h0;

  typedef struct packed {
    logic lane_b;
    logic lane_a;
  } serial_out_t;

  localparam serial_out_t SER_RST = '{lane_b: 1'b0, lane_a: 1'b0};

endpackage : gearbox_pkg

//--- hdl/output_serializer_gearbox.sv
// output serializer gearbox: parallel core words to high-speed serial lanes
`timescale 1ns/100ps
// ==========================================================
// Overview of operation
// - serialize up to eight bits per word
// - seven-to-one mode using seven bits
// - eight-to-one mode using all eight bits
// - two independent four-to-one lanes
// - lanes: 6:0, 7:0, 3:0 and 7:4
// - stage one registers the parallel word
// - stage two transfers word to fast domain
// - stage three shifts bits onto serial output
module output_serializer_gearbox (
  input wire logic sys_clk,
  input wire logic rst,
  input wire gearbox_pkg::gear_mode_t mode,
  input wire logic [gearbox_pkg::WORD_W-1:0] d,
  output gearbox_pkg::serial_out_t ser_q,
  output logic slow_clk_q
);
  import gearbox_pkg::*;

  // ==========================================================
  // word framing
  logic [3:0] slot_q;
  logic [3:0] slot_d;
  logic [3:0] word_len;
  logic last_slot;
  logic four_mode;

  assign word_len = (mode == MODE_SEVEN_TO_ONE) ? LEN_SEVEN :
                    (mode == MODE_FOUR_TO_ONE) ? LEN_FOUR : LEN_EIGHT;
  assign last_slot = (slot_q >= word_len - 4'h1);
  assign slot_d = last_slot ? SLOT_RST : slot_q + 4'h1;
  assign four_mode = (mode == MODE_FOUR_TO_ONE);

  // ==========================================================
  // pipeline stages
  logic [WORD_W-1:0] in_q;
  logic [WORD_W-1:0] in_d;
  logic [WORD_W-1:0] xfer_q;
  logic [WORD_W-1:0] xfer_d;
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] shift_d;
  logic [WORD_W-1:0] lane_mask;
  logic [WORD_W-1:0] src;
  serial_out_t ser_d;

  // unused lanes are forced to zero so stale bits never reach the pad
  assign lane_mask = (mode == MODE_SEVEN_TO_ONE) ? 8'h7f : 8'hff;
  assign in_d = (slot_q == SLOT_CAPTURE) ? (d & lane_mask) : in_q;
  assign xfer_d = (slot_q == SLOT_TRANSFER) ? in_q : xfer_q;
  assign src = (slot_q == SLOT_LOAD) ? xfer_q : shift_q;

  // in four-to-one mode each nibble shifts on its own
  genvar gi;
  generate
    for (gi = 0; gi < WORD_W; gi++) begin : g_shift
      if ((gi == LANE_B_BIT - 1) || (gi == WORD_W - 1)) begin : g_top
        assign shift_d[gi] = 1'b0;
      end else begin : g_mid
        assign shift_d[gi] = src[gi + 1];
      end
    end
  endgenerate

  assign ser_d.lane_a = src[0];
  assign ser_d.lane_b = four_mode ? src[LANE_B_BIT] : 1'b0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slot_q <= SLOT_RST;
      in_q <= WORD_RST;
      xfer_q <= WORD_RST;
      shift_q <= WORD_RST;
      ser_q <= SER_RST;
      slow_clk_q <= 1'b0;
    end else begin
      slot_q <= slot_d;
      in_q <= in_d;
      xfer_q <= xfer_d;
      shift_q <= four_mode ? shift_d : {1'b0, src[WORD_W-1:1]};
      ser_q <= ser_d;
      slow_clk_q <= (slot_d < (word_len >> 1));
    end
  end

  // ==========================================================
  // assertions
  sequence s_load8;
    (slot_q == SLOT_LOAD && mode == MODE_EIGHT_TO_ONE) ##1 (mode == MODE_EIGHT_TO_ONE) [*7];
  endsequence

  sequence s_load7;
    (slot_q == SLOT_LOAD && mode == MODE_SEVEN_TO_ONE) ##1 (mode == MODE_SEVEN_TO_ONE) [*6];
  endsequence

  sequence s_load4;
    (slot_q == SLOT_LOAD && mode == MODE_FOUR_TO_ONE) ##1 (mode == MODE_FOUR_TO_ONE) [*3];
  endsequence

  a_reset_out_low: assert property (@(posedge sys_clk)
    $fell(rst) |-> (ser_q == SER_RST && slot_q == SLOT_RST))
    else $error("output not low after reset");

  a_stage_one_capture: assert property (@(posedge sys_clk) disable iff (rst)
    (slot_q == SLOT_CAPTURE && mode == MODE_EIGHT_TO_ONE) |=> in_q == $past(d))
    else $error("stage one missed the word");

  a_stage_two_xfer: assert property (@(posedge sys_clk) disable iff (rst)
    (slot_q == SLOT_TRANSFER) |=> xfer_q == $past(in_q))
    else $error("stage two missed the transfer");

  a_stage_three_first: assert property (@(posedge sys_clk) disable iff (rst)
    (slot_q == SLOT_LOAD) |=> ser_q.lane_a == $past(xfer_q[0]))
    else $error("first serial bit wrong");

  a_seven_slot_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    (mode == MODE_SEVEN_TO_ONE && slot_q == 4'h6) |=> slot_q == SLOT_RST)
    else $error("seven-bit word length wrong");

  a_eight_last_bit: assert property (@(posedge sys_clk) disable iff (rst)
    s_load8 |=> ser_q.lane_a == $past(xfer_q[7], 8))
    else $error("eighth serial bit wrong");

  a_seven_last_bit: assert property (@(posedge sys_clk) disable iff (rst)
    s_load7 |=> ser_q.lane_a == $past(xfer_q[6], 7))
    else $error("seventh serial bit wrong");

  a_four_lane_b: assert property (@(posedge sys_clk) disable iff (rst)
    s_load4 |=> (ser_q.lane_b == $past(xfer_q[7], 4) && ser_q.lane_a == $past(xfer_q[3], 4)))
    else $error("four-to-one lanes wrong");

  a_lane_b_idle: assert property (@(posedge sys_clk) disable iff (rst)
    (mode != MODE_FOUR_TO_ONE) |=> ser_q.lane_b == 1'b0)
    else $error("second lane active outside four-to-one");

  // ==========================================================
  // further assertions: reset, word steps, slot counter, spare mode and slow clock
  sequence s_held_reset;
    rst ##1 rst;
  endsequence

  sequence s_capture7;
    slot_q == SLOT_CAPTURE && mode == MODE_SEVEN_TO_ONE;
  endsequence

  sequence s_capture4;
    slot_q == SLOT_CAPTURE && mode == MODE_FOUR_TO_ONE;
  endsequence

  sequence s_load4_first;
    slot_q == SLOT_LOAD && mode == MODE_FOUR_TO_ONE;
  endsequence

  sequence s_load4_mid;
    (slot_q == SLOT_LOAD && mode == MODE_FOUR_TO_ONE) ##1 (mode == MODE_FOUR_TO_ONE);
  endsequence

  sequence s_load8_two;
    (slot_q == SLOT_LOAD && mode == MODE_EIGHT_TO_ONE) ##1 (mode == MODE_EIGHT_TO_ONE);
  endsequence

  sequence s_load8_mid;
    (slot_q == SLOT_LOAD && mode == MODE_EIGHT_TO_ONE) ##1 (mode == MODE_EIGHT_TO_ONE) [*3];
  endsequence

  a_reset_clears_all: assert property (@(posedge sys_clk)
    s_held_reset |-> (in_q == WORD_RST && xfer_q == WORD_RST && shift_q == WORD_RST))
    else $error("pipeline not cleared in reset");

  a_reset_holds_low: assert property (@(posedge sys_clk)
    s_held_reset |-> (ser_q == SER_RST && slow_clk_q == 1'b0))
    else $error("outputs not low in reset");

  a_reset_slow_low: assert property (@(posedge sys_clk)
    $fell(rst) |-> slow_clk_q == 1'b0)
    else $error("slow clock high after reset");

  a_seven_top_masked: assert property (@(posedge sys_clk) disable iff (rst)
    s_capture7 |=> in_q == {1'b0, $past(d[6:0])})
    else $error("seven-bit word not masked");

  a_four_capture_both: assert property (@(posedge sys_clk) disable iff (rst)
    s_capture4 |=> in_q == $past(d))
    else $error("four-to-one nibbles not captured");

  a_capture_word_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (slot_q != SLOT_CAPTURE) |=> $stable(in_q))
    else $error("stage one changed outside capture");

  a_xfer_word_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (slot_q != SLOT_TRANSFER) |=> $stable(xfer_q))
    else $error("stage two changed outside transfer");

  a_four_first_pair: assert property (@(posedge sys_clk) disable iff (rst)
    s_load4_first |=> (ser_q.lane_a == $past(xfer_q[0]) &&
      ser_q.lane_b == $past(xfer_q[LANE_B_BIT])))
    else $error("first four-to-one pair wrong");

  a_four_mid_pair: assert property (@(posedge sys_clk) disable iff (rst)
    s_load4_mid |=> (ser_q.lane_a == $past(xfer_q[1], 2) &&
      ser_q.lane_b == $past(xfer_q[5], 2)))
    else $error("second four-to-one pair wrong");

  a_eight_second_bit: assert property (@(posedge sys_clk) disable iff (rst)
    s_load8_two |=> ser_q.lane_a == $past(xfer_q[1], 2))
    else $error("second serial bit wrong");

  a_eight_mid_bit: assert property (@(posedge sys_clk) disable iff (rst)
    s_load8_mid |=> ser_q.lane_a == $past(xfer_q[3], 4))
    else $error("fourth serial bit wrong");

  a_slot_wrap_any: assert property (@(posedge sys_clk) disable iff (rst)
    (slot_q >= word_len - 4'h1) |=> slot_q == SLOT_RST)
    else $error("slot counter did not wrap");

  a_slot_step_one: assert property (@(posedge sys_clk) disable iff (rst)
    (slot_q < word_len - 4'h1) |=> slot_q == $past(slot_q) + 4'h1)
    else $error("slot counter skipped");

  a_four_slot_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    (mode == MODE_FOUR_TO_ONE && slot_q == 4'h3) |=> slot_q == SLOT_RST)
    else $error("four-bit word length wrong");

  a_spare_mode_eight: assert property (@(posedge sys_clk) disable iff (rst)
    (mode == gear_mode_t'(2'b11)) |-> (word_len == LEN_EIGHT && lane_mask == 8'hff))
    else $error("spare mode not eight-to-one");

  a_slow_clock_phase: assert property (@(posedge sys_clk) disable iff (rst)
    (!rst) |=> slow_clk_q == (slot_q < (word_len >> 1)))
    else $error("slow clock phase wrong");

endmodule : output_serializer_gearbox

//--- tb/line_receiver.sv
// far-end receiver model: gathers serial bits lsb first
`timescale 1ns/100ps
module line_receiver (
  input wire logic sys_clk,
  input wire gearbox_pkg::serial_out_t ser_q,
  output logic [7:0] rx_a_q,
  output logic [7:0] rx_b_q
);
  import gearbox_pkg::*;
  // ==========================================================
  // shift in one bit per edge
  always_ff @(posedge sys_clk) begin
    rx_a_q <= {ser_q.lane_a, rx_a_q[7:1]};
    rx_b_q <= {ser_q.lane_b, rx_b_q[7:1]};
  end
endmodule : line_receiver

//--- tb/output_serializer_gearbox_tb_top.sv
// testbench of the output serializer gearbox
`timescale 1ns/100ps
module output_serializer_gearbox_tb_top;
  import gearbox_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  gear_mode_t mode = MODE_EIGHT_TO_ONE;
  logic [7:0] d = 8'h00;
  serial_out_t ser_q;
  logic slow_clk_q;
  logic [7:0] rx_a_q, rx_b_q;
  int failures = 0;
  int compares = 0;
  // ==========================================================
  // clock, design and receiver
  always #20 sys_clk = ~sys_clk;
  output_serializer_gearbox DUT (.sys_clk(sys_clk), .rst(rst), .mode(mode), .d(d),
    .ser_q(ser_q), .slow_clk_q(slow_clk_q));
  line_receiver rx (.sys_clk(sys_clk), .ser_q(ser_q), .rx_a_q(rx_a_q), .rx_b_q(rx_b_q));
  // ==========================================================
  // shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] got(input int len);
    return (len == 4) ? {rx_b_q[7:4], rx_a_q[7:4]} : rx_a_q >> (8 - len);
  endfunction : got
  // reset, then two words back to back
  task automatic send(input gear_mode_t m, input int len, input logic [7:0] w0, w1);
    logic [7:0] mask;
    int highs;
    mask = (len == 7) ? 8'h7f : 8'hff;
    highs = 0;
    @(negedge sys_clk);
    rst = 1'b1;
    mode = m;
    d = w0;
    repeat (2) @(negedge sys_clk);
    check({5'h00, ser_q, slow_clk_q}, 8'h00);
    rst = 1'b0;
    @(negedge sys_clk);
    d = w1;
    repeat (len + 2) @(negedge sys_clk);
    check(got(len), w0 & mask);
    if (len != 4) check(rx_b_q, 8'h00);
    repeat (len) @(negedge sys_clk);
    check(got(len), w1 & mask);
    repeat (len) begin
      @(negedge sys_clk);
      if (slow_clk_q === 1'b1) highs++;
    end
    check(8'(highs), 8'(len / 2));
  endtask : send
  // ==========================================================
  // scenarios
  task automatic test_seven;
    send(MODE_SEVEN_TO_ONE, 7, 8'hb5, 8'hca);
    $display("seven to one done");
  endtask : test_seven
  task automatic test_eight;
    send(MODE_EIGHT_TO_ONE, 8, 8'h96, 8'h3c);
    send(gear_mode_t'(2'b11), 8, 8'h81, 8'h7e);
    $display("eight to one done");
  endtask : test_eight
  task automatic test_four;
    send(MODE_FOUR_TO_ONE, 4, 8'ha5, 8'h5c);
    $display("four to one done");
  endtask : test_four
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    test_seven();
    test_eight();
    test_four();
    wrap_up();
  end
  initial begin
    #40000;
    failures++;
    wrap_up();
  end
endmodule : output_serializer_gearbox_tb_top
